// ### verilog/pcs_pkg.sv
// Package for the pixel channel sequencer: register indices, field
// positions, reset values and mode enumeration.
// Assumes a 32-bit APB with one aligned word per register.
package pcs_pkg;
    // Register indices; byte address is four times the index
    localparam logic [2:0] PCS_IDX_CFG = 3'h0;  // Configuration register
    localparam logic [2:0] PCS_IDX_MUX = 3'h1;  // Multiplexer setup register
    localparam logic [2:0] PCS_IDX_STAT = 3'h2; // Status register
    localparam int PCS_REG_W = 9;               // Width of programmable registers
    // Configuration register fields
    localparam int PCS_CFG_ONE_BYTE = 0;        // Single byte output
    localparam int PCS_CFG_PWR_DN = 2;          // Power-down request
    localparam int PCS_CFG_CLAMP_BIAS = 3;      // Clamp bias select
    localparam int PCS_CFG_CDS = 4;             // Correlated double sampling on
    localparam int PCS_CFG_THREE_CH = 5;        // Three-channel operation
    localparam int PCS_CFG_VREF = 6;            // Internal reference on
    localparam int PCS_CFG_RANGE = 7;           // Input range select
    // Multiplexer setup register fields
    localparam int PCS_MUX_BLUE = 4;            // Blue select
    localparam int PCS_MUX_GREEN = 5;           // Green select
    localparam int PCS_MUX_RED = 6;             // Red select
    localparam int PCS_MUX_RGB = 7;             // Order red-green-blue
    // Values after reset
    localparam logic [8:0] PCS_CFG_RESET = 9'h0f8;
    localparam logic [8:0] PCS_MUX_RESET = 9'h0c0;
    // Converter pipeline depth in converter-clock cycles
    localparam int PCS_LATENCY = 3;
    // Channel codes
    localparam logic [1:0] PCS_CH_RED = 2'h0;
    localparam logic [1:0] PCS_CH_GREEN = 2'h1;
    localparam logic [1:0] PCS_CH_BLUE = 2'h2;
    // Operating modes
    typedef enum logic [2:0] {
        PCS_M3_CDS,
        PCS_M3_SHA,
        PCS_M2_CDS,
        PCS_M2_SHA,
        PCS_M1_CDS,
        PCS_M1_SHA,
        PCS_M_IDLE
    } pcs_mode_e;
endpackage : pcs_pkg

// ### verilog/pcs_edge.sv
// Edge detector for a group of inputs already synchronous to pclk.
// Assumes the inputs change only after rising pclk edges.
`timescale 1ns/1ps
module pcs_edge #(
    parameter int W = 3
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic [W-1:0] sig,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    logic [W-1:0] prev_q; // Level seen on the previous enabled edge

    // Remember last level per input
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q <= '0;
        end else if (ce) begin
            prev_q <= sig;
        end
    end

    // One-cycle edge flags per bit
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_edge
            assign rise[i] = sig[i] & ~prev_q[i];
            assign fall[i] = ~sig[i] & prev_q[i];
        end
    endgenerate
endmodule : pcs_edge

// ### verilog/pcs_pixel_channel_sequencer.sv
// Pixel channel sequencer: strobe capture, channel multiplexer, converter
// pipeline and byte output, with APB configuration registers.
// Assumes strobes, converter clock and levels are synchronous to pclk.
//
// Notes on behaviour
// - Six modes from channel count and sampling type.
// - Level strobe rise resets multiplexer sequence.
// - Three-channel correlated, RGB order: first rise selects red.
// - Converter samples selected output on falling edge.
// - Multiplexer advances on converter clock rise.
// - All active channels captured at level fall.
// - Correlated: reference and level captured, difference kept.
// - Output appears three converter cycles later.
// - Hold modes capture only at level fall.
// - Clamp disabled in sample-and-hold modes.
// - Two selects with three-channel bit clear: two-channel.
// - Pairs red-green, red-blue, green-blue supported.
// - Order bit chooses forward or reverse pair order.
// - Three-channel order RGB or BGR, restarting each pulse.
// - One-channel keeps multiplexer on selected channel.
// - Config bit D4 selects correlated or hold.
// - Two-byte mode: high after rise, low after fall.
`timescale 1ns/1ps
module pcs_pixel_channel_sequencer
    import pcs_pkg::*;
#(
    parameter int DW = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic reference_sample_strobe,
    input wire logic level_sample_strobe,
    input wire logic converter_clock,
    input wire logic [DW-1:0] red_level,
    input wire logic [DW-1:0] green_level,
    input wire logic [DW-1:0] blue_level,
    output logic [7:0] sample_byte,
    output logic [1:0] sample_channel,
    output logic clamp_enable,
    output logic power_down
);
    // Programmable registers
    logic [8:0] cfg_q;
    logic [8:0] mux_q;
    logic [31:0] prdata_q;
    // Edge flags: bit0 reference, bit1 level, bit2 converter clock
    logic [2:0] rise;
    logic [2:0] fall;
    // Multiplexer state
    logic pend_q;
    logic [1:0] slot_q;
    logic [1:0] slot_d;
    logic [1:0] sel_q;
    // Channel storage
    logic [DW-1:0] lvl [3];
    logic [DW-1:0] ref_q [3];
    logic [DW-1:0] held_q [3];
    // Converter pipeline and output
    logic [DW-1:0] pipe_q [PCS_LATENCY];
    logic [1:0] pch_q [PCS_LATENCY];
    logic [DW-1:0] out_word_q;
    logic [7:0] byte_q;
    logic [1:0] och_q;
    // Decoded mode
    logic correlated_double_sampling;
    logic three;
    logic rgb;
    logic [2:0] mask;
    logic [1:0] n_act;
    pcs_mode_e mode;
    logic wr_en;
    logic [2:0] idx;
    logic mapped;

    // Count of ones in a channel mask
    function automatic logic [1:0] pcs_count(input logic [2:0] m);
        pcs_count = {1'b0, m[0]} + {1'b0, m[1]} + {1'b0, m[2]};
    endfunction : pcs_count

    // Channel at a given position in the ordered active list
    function automatic logic [1:0] pcs_seq_ch(input logic [1:0] slot, input logic [2:0] m,
                                              input logic order_rgb);
        logic [1:0] cnt;
        logic [1:0] ch;
        pcs_seq_ch = PCS_CH_RED;
        cnt = 2'h0;
        for (int k = 0; k < 3; k++) begin
            ch = order_rgb ? 2'(k) : 2'(2 - k);
            if (m[ch]) begin
                if (cnt == slot) begin
                    pcs_seq_ch = ch;
                end
                cnt = cnt + 2'h1;
            end
        end
    endfunction : pcs_seq_ch

    // Operating mode from channel count and sampling type
    function automatic pcs_mode_e pcs_mode(input logic [1:0] n, input logic c);
        case (n)
            2'h3: pcs_mode = c ? PCS_M3_CDS : PCS_M3_SHA;
            2'h2: pcs_mode = c ? PCS_M2_CDS : PCS_M2_SHA;
            2'h1: pcs_mode = c ? PCS_M1_CDS : PCS_M1_SHA;
            default: pcs_mode = PCS_M_IDLE;
        endcase
    endfunction : pcs_mode

    // Mode decode from the two registers
    assign correlated_double_sampling = cfg_q[PCS_CFG_CDS];
    assign three = cfg_q[PCS_CFG_THREE_CH];
    assign rgb = mux_q[PCS_MUX_RGB];
    // Three-channel bit overrides the selects; else selects pick the set
    assign mask = three ? 3'h7 : {mux_q[PCS_MUX_BLUE], mux_q[PCS_MUX_GREEN],
                                  mux_q[PCS_MUX_RED]};
    assign n_act = pcs_count(mask);
    assign mode = pcs_mode(n_act, correlated_double_sampling);
    assign clamp_enable = correlated_double_sampling;
    assign power_down = cfg_q[PCS_CFG_PWR_DN];

    // Channel levels as an array
    assign lvl[0] = red_level;
    assign lvl[1] = green_level;
    assign lvl[2] = blue_level;

    // Strobe and converter clock edges
    pcs_edge #(
        .W(3)
    ) u_edge (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .sig({converter_clock, level_sample_strobe, reference_sample_strobe}),
        .rise(rise),
        .fall(fall)
    );

    // APB decode: zero wait states while enabled
    assign idx = paddr[4:2];
    assign mapped = (paddr[1:0] == 2'h0) && (paddr[7:5] == 3'h0) && (idx <= PCS_IDX_STAT);
    assign pready = ce;
    assign pslverr = psel & penable & ~mapped;
    assign wr_en = psel & penable & pwrite & ce & mapped;
    assign prdata = prdata_q;

    // Register writes; status is read-only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= PCS_CFG_RESET;
            mux_q <= PCS_MUX_RESET;
        end else if (wr_en) begin
            case (idx)
                PCS_IDX_CFG: cfg_q <= pwdata[8:0];
                PCS_IDX_MUX: mux_q <= pwdata[8:0];
                default: ;
            endcase
        end
    end

    // Read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0;
        end else if (ce && psel && !penable) begin
            // Unmapped or misaligned addresses read as zero
            case (mapped ? idx : 3'h7)
                PCS_IDX_CFG: prdata_q <= {23'h0, cfg_q};
                PCS_IDX_MUX: prdata_q <= {23'h0, mux_q};
                PCS_IDX_STAT: prdata_q <= {out_word_q, 6'h0, pend_q, 2'(slot_q),
                                            sel_q, n_act, 3'(mode)};
                default: prdata_q <= 32'h0;
            endcase
        end
    end

    // Reset request from level strobe rise, consumed at next converter rise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q <= 1'b0;
        end else if (ce) begin
            if (rise[1]) begin
                pend_q <= 1'b1;
            end else if (rise[2]) begin
                pend_q <= 1'b0;
            end
        end
    end

    // Next sequence position
    always_comb begin
        if (pend_q || n_act <= 2'h1) begin
            slot_d = 2'h0;
        end else if (slot_q >= n_act - 2'h1) begin
            slot_d = 2'h0;
        end else begin
            slot_d = slot_q + 2'h1;
        end
    end

    // Multiplexer steps on converter clock rise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot_q <= 2'h0;
            sel_q <= PCS_CH_RED;
        end else if (ce && rise[2]) begin
            slot_q <= slot_d;
            sel_q <= pcs_seq_ch(slot_d, mask, rgb);
        end
    end

    // Per-channel reference and level capture
    genvar c;
    generate
        for (c = 0; c < 3; c++) begin : g_ch
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ref_q[c] <= '0;
                    held_q[c] <= '0;
                end else if (ce && mask[c]) begin
                    // Reference taken only when correlated
                    if (correlated_double_sampling && fall[0]) begin
                        ref_q[c] <= lvl[c];
                    end
                    // Data level on level strobe fall, all active channels at once
                    if (fall[1]) begin
                        held_q[c] <= correlated_double_sampling ? lvl[c] - ref_q[c] : lvl[c];
                    end
                end
            end
        end
    endgenerate

    // Converter samples held value on converter clock fall
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < PCS_LATENCY; i++) begin
                pipe_q[i] <= '0;
                pch_q[i] <= PCS_CH_RED;
            end
        end else if (ce && fall[2] && n_act != 2'h0) begin
            pipe_q[0] <= held_q[sel_q];
            pch_q[0] <= sel_q;
            for (int i = 1; i < PCS_LATENCY; i++) begin
                pipe_q[i] <= pipe_q[i-1];
                pch_q[i] <= pch_q[i-1];
            end
        end
    end

    // Result word leaves the pipeline on converter rise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_word_q <= '0;
            och_q <= PCS_CH_RED;
        end else if (ce && rise[2]) begin
            out_word_q <= pipe_q[PCS_LATENCY-1];
            och_q <= pch_q[PCS_LATENCY-1];
        end
    end

    // Byte output: high byte after rise, low byte after fall in two-byte mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            byte_q <= 8'h0;
        end else if (ce) begin
            if (rise[2]) begin
                byte_q <= pipe_q[PCS_LATENCY-1][DW-1 -: 8];
            end else if (fall[2] && !cfg_q[PCS_CFG_ONE_BYTE]) begin
                byte_q <= out_word_q[7:0];
            end
        end
    end
    assign sample_byte = byte_q;
    assign sample_channel = och_q;

    // Checks on the sequencing and data path
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_mux_reset: assert property (ce && rise[1] |=> pend_q)
        else $error("level strobe rise did not arm multiplexer reset");
    a_red_first: assert property (ce && rise[2] && pend_q && three && rgb
                                  |=> sel_q == PCS_CH_RED)
        else $error("first channel after level strobe is not red");
    a_mux_step: assert property (ce && rise[2] && !pend_q && n_act == 2'h3
                                 |=> slot_q == (($past(slot_q) == 2'h2) ? 2'h0
                                                : $past(slot_q) + 2'h1))
        else $error("multiplexer did not advance one position");
    a_one_fixed: assert property (ce && rise[2] && n_act == 2'h1
                                  |=> mask[sel_q] && slot_q == 2'h0)
        else $error("one-channel multiplexer moved off its channel");
    a_clamp_off: assert property (!cfg_q[PCS_CFG_CDS] |-> !clamp_enable)
        else $error("clamp left enabled in sample-and-hold mode");
    a_conv_sample: assert property (ce && fall[2] && n_act != 2'h0
                                    |=> pipe_q[0] == $past(held_q[sel_q]))
        else $error("converter did not take the selected channel");
    a_out_latency: assert property (ce && rise[2]
                                    |=> out_word_q == $past(pipe_q[PCS_LATENCY-1]))
        else $error("output word not the third pipeline stage");
    a_low_byte: assert property (ce && fall[2] && !rise[2] && !cfg_q[PCS_CFG_ONE_BYTE]
                                 |=> sample_byte == $past(out_word_q[7:0]))
        else $error("low byte missing after converter fall");
    a_cds_diff: assert property (ce && fall[1] && correlated_double_sampling && mask[0]
                                 |=> held_q[0] == $past(red_level - ref_q[0]))
        else $error("red correlated result is not the difference");
    a_hold_level: assert property (ce && fall[1] && !correlated_double_sampling && mask[2]
                                   |=> held_q[2] == $past(blue_level))
        else $error("blue held level not captured in hold mode");
    a_ref_capture: assert property (ce && fall[0] && correlated_double_sampling && mask[1]
                                    |=> ref_q[1] == $past(green_level))
        else $error("green reference level not captured");
    a_all_capture: assert property (ce && fall[1] && !correlated_double_sampling && mask[0] && mask[1]
                                    |=> held_q[0] == $past(red_level)
                                        && held_q[1] == $past(green_level))
        else $error("active channels not captured together");
    a_pair_first: assert property (ce && rise[2] && pend_q && n_act == 2'h2
                                   |=> sel_q == ($past(rgb)
                                                 ? ($past(mask[0]) ? PCS_CH_RED : PCS_CH_GREEN)
                                                 : ($past(mask[2]) ? PCS_CH_BLUE : PCS_CH_GREEN)))
        else $error("two-channel sequence did not restart at first member");
    a_three_order: assert property (ce && rise[2] && pend_q && three && !rgb
                                    |=> sel_q == PCS_CH_BLUE)
        else $error("reverse three-channel order did not start at blue");
    a_high_byte: assert property (ce && rise[2] |=> sample_byte == out_word_q[DW-1 -: 8])
        else $error("high byte not shown after converter rise");
    a_byte_hold: assert property (ce && !rise[2] && !fall[2] |=> $stable(sample_byte))
        else $error("output byte changed without a converter edge");
endmodule : pcs_pixel_channel_sequencer

// ### testbench/pcs_scan_model.sv
// Scanner timing controller model: drives the sample strobes, the converter
// clock and the three channel levels, one pixel per call of pixel().
// Assumes pclk is the bench clock; every change follows its rising edge.
`timescale 1ns/1ps
module pcs_scan_model (
    input wire logic pclk,
    output logic reference_sample_strobe,
    output logic level_sample_strobe,
    output logic converter_clock,
    output logic [15:0] red_level,
    output logic [15:0] green_level,
    output logic [15:0] blue_level
);
    // Quiet lines at time zero
    initial begin
        reference_sample_strobe = 1'b0;
        level_sample_strobe = 1'b0;
        converter_clock = 1'b0;
        red_level = 16'h0000;
        green_level = 16'h0000;
        blue_level = 16'h0000;
    end

    // One level set on all three channel inputs
    task automatic put(input logic [15:0] r, input logic [15:0] g, input logic [15:0] b);
        red_level <= r;
        green_level <= g;
        blue_level <= b;
    endtask : put

    // One pixel: reference, data level, then n converter cycles
    task automatic pixel(input logic correlated_double_sampling, input logic [15:0] base, input int n,
                         input int half);
        @(posedge pclk);
        put(16'h0011, 16'h0021, 16'h0031);
        reference_sample_strobe <= correlated_double_sampling;
        repeat (2) @(posedge pclk);
        reference_sample_strobe <= 1'b0;
        repeat (2) @(posedge pclk);
        put(base + 16'h0100, base + 16'h0200, base + 16'h0300);
        level_sample_strobe <= 1'b1;
        repeat (2) @(posedge pclk);
        level_sample_strobe <= 1'b0;
        repeat (2) @(posedge pclk);
        // Levels no longer held: show their inverse so a late capture shows
        put(~red_level, ~green_level, ~blue_level);
        for (int i = 0; i < n; i++) begin
            converter_clock <= 1'b1;
            repeat (half) @(posedge pclk);
            converter_clock <= 1'b0;
            repeat (half) @(posedge pclk);
        end
    endtask : pixel
endmodule : pcs_scan_model

// ### testbench/tb_top.sv
// Self-checking bench for the pixel channel sequencer: APB reset and refusal
// cases, a table of modes run through the scanner model, then power-down and reset.
// Assumes the scanner model drives strobes, converter clock and levels.
`timescale 1ns/1ps
module tb_top
    import pcs_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic reference_sample_strobe;
    logic level_sample_strobe;
    logic converter_clock;
    logic [15:0] red_level;
    logic [15:0] green_level;
    logic [15:0] blue_level;
    logic [7:0] sample_byte;
    logic [1:0] sample_channel;
    logic clamp_enable;
    logic power_down;
    int failures = 0;
    int samples_checked = 0;
    int rises = 0;
    logic one_byte = 1'b0;
    logic have;
    logic [17:0] cur;
    logic [17:0] exp_q [$]; // Channel and word, one per converter rise
    logic [31:0] rd;
    logic err;
    logic [15:0] base = 16'h2345;
    logic [1:0] ch;
    // Mode row: registers, status mode code, cycles, channel order
    typedef struct {
        logic [8:0] cfg;
        logic [8:0] mux;
        logic [2:0] mode;
        int n;
        logic [5:0] chs;
    } pcs_tbrow_s;
    pcs_tbrow_s rows [12] = '{
        '{9'h0f8, 9'h0c0, 3'h0, 3, 6'h06}, '{9'h0f8, 9'h040, 3'h0, 3, 6'h24},
        '{9'h0e8, 9'h0c0, 3'h1, 3, 6'h06}, '{9'h0f8, 9'h0c0, 3'h0, 2, 6'h04},
        '{9'h0d8, 9'h0e0, 3'h2, 2, 6'h04}, '{9'h0d8, 9'h050, 3'h2, 2, 6'h20},
        '{9'h0c8, 9'h0b0, 3'h3, 2, 6'h18}, '{9'h0c8, 9'h030, 3'h3, 2, 6'h24},
        '{9'h0c8, 9'h0d0, 3'h3, 2, 6'h08}, '{9'h0d8, 9'h020, 3'h4, 2, 6'h14},
        '{9'h0c8, 9'h010, 3'h5, 2, 6'h28}, '{9'h0f9, 9'h0c0, 3'h0, 3, 6'h06}};

    pcs_pixel_channel_sequencer #(.DW(16)) u_pcs_pixel_channel_sequencer (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .reference_sample_strobe(reference_sample_strobe),
        .level_sample_strobe(level_sample_strobe), .converter_clock(converter_clock),
        .red_level(red_level), .green_level(green_level), .blue_level(blue_level),
        .sample_byte(sample_byte), .sample_channel(sample_channel),
        .clamp_enable(clamp_enable), .power_down(power_down));

    pcs_scan_model u_pcs_scan_model (
        .pclk(pclk), .reference_sample_strobe(reference_sample_strobe),
        .level_sample_strobe(level_sample_strobe), .converter_clock(converter_clock),
        .red_level(red_level), .green_level(green_level), .blue_level(blue_level));

    // 200 MHz clock
    always #2.5 pclk = ~pclk;

    // Count one comparison, report a miss
    task automatic chk(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            failures++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : chk

    // Summary and verdict, then end of run
    task automatic report_and_stop();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Expected word: data level, less the reference when correlated
    function automatic logic [15:0] exp_val(input logic [1:0] c, input logic [15:0] b,
                                            input logic correlated_double_sampling);
        logic [15:0] d;
        logic [15:0] r;
        d = b + {6'h00, c, 8'h00} + 16'h0100;
        r = 16'h0011 + {10'h000, c, 4'h0};
        return correlated_double_sampling ? d - r : d;
    endfunction : exp_val

    // Output monitor: word selected three converter rises earlier
    initial begin
        forever begin
            @(posedge converter_clock);
            repeat (4) @(posedge pclk);
            have = (rises >= PCS_LATENCY) && (exp_q.size() > 0);
            if (have) begin
                cur = exp_q.pop_front();
                chk(sample_byte === cur[15:8] && sample_channel === cur[17:16], "high byte");
            end
            rises++;
            @(negedge converter_clock);
            repeat (4) @(posedge pclk);
            if (have) chk(sample_byte === (one_byte ? cur[15:8] : cur[7:0]), "low byte");
        end
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        $display("mismatch at %0t: watchdog expired", $time);
        report_and_stop();
    end

    // Main sequence
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        chk(clamp_enable === 1'b1 && power_down === 1'b0 && sample_byte === 8'h00, "reset pins");
        apb(1'b0, 8'h00, 32'h0, rd, err);
        chk(rd[8:0] === 9'h0f8, "config reset");
        apb(1'b0, 8'h04, 32'h0, rd, err);
        chk(rd[8:0] === 9'h0c0, "mux reset");
        apb(1'b0, 8'h0c, 32'h0, rd, err);
        chk(err === 1'b1 && rd === 32'h0, "unmapped read");
        apb(1'b1, 8'h02, 32'h0, rd, err);
        chk(err === 1'b1, "misaligned write");
        // Mode table: program, check mode code and clamp, run two pixels
        foreach (rows[k]) begin
            apb(1'b1, 8'h00, {23'h0, rows[k].cfg}, rd, err);
            apb(1'b1, 8'h04, {23'h0, rows[k].mux}, rd, err);
            one_byte <= rows[k].cfg[0];
            apb(1'b0, 8'h08, 32'h0, rd, err);
            chk(rd[2:0] === rows[k].mode, "mode code");
            chk(rd[4:3] === (rows[k].cfg[5] ? 2'h3 : 2'($countones(rows[k].mux[6:4]))), "count");
            chk(clamp_enable === rows[k].cfg[4], "clamp");
            for (int p = 0; p < 2; p++) begin
                base = base + 16'h1357;
                for (int i = 0; i < rows[k].n; i++) begin
                    ch = rows[k].chs[5 - 2 * i -: 2];
                    exp_q.push_back({ch, exp_val(ch, base, rows[k].cfg[4])});
                end
                u_pcs_scan_model.pixel(rows[k].cfg[4], base, rows[k].n, p ? 9 : 6);
            end
        end
        apb(1'b1, 8'h00, 32'h0fc, rd, err);
        // Write lands at the access edge; look one edge later
        @(posedge pclk);
        chk(power_down === 1'b1, "power down");
        // Second reset in mid-run
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h00, 32'h0, rd, err);
        chk(rd[8:0] === 9'h0f8 && sample_byte === 8'h00, "second reset");
        report_and_stop();
    end
endmodule : tb_top
